//--- design/event_message_pkg.sv
package event_message_pkg;

    localparam int unsigned FIFO_DEPTH = 2048;
    localparam int unsigned PTR_W = 11;
    localparam int unsigned CNT_W = 12;
    localparam logic [CNT_W-1:0] CNT_FULL = 12'h800;
    localparam logic [CNT_W-1:0] CNT_HALF = 12'h400;
    localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;

    // Register byte offsets (word aligned)
    localparam logic [3:0] OFS_MESSAGE = 4'h0;
    localparam logic [3:0] OFS_DEBUG = 4'h4;
    localparam logic [3:0] OFS_COMMAND = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    // Mask bits 0..5 debug classes, 6 info, 7 error, 8 netmap
    localparam int unsigned MASK_W = 9;
    localparam logic [MASK_W-1:0] MASK_RESET = 9'h1C0;
    localparam logic [3:0] CLS_INFO = 4'h6;
    localparam logic [3:0] CLS_ERROR = 4'h7;
    localparam logic [3:0] CLS_NETMAP = 4'h8;
    localparam logic [3:0] CLS_ALWAYS = 4'h9;

    localparam logic [7:0] STS_SUCCESS = 8'h02;
    localparam logic [7:0] STS_REFUSED = 8'h04;
    localparam logic [7:0] STS_INVALID = 8'h09;

    // Command codes, arbitrary within the shared code space
    localparam logic [7:0] SET_DEBUG_FILTER_COMMAND = 8'h20;
    localparam logic [7:0] NODE_LIST_REQUEST_COMMAND = 8'h21;
    localparam logic [7:0] NULL_CODE = 8'h00;
    localparam logic [3:0] NODE_LIST_MAX = 4'h8;
    localparam logic [7:0] LAST_NODE_ID = 8'hFF;

    localparam logic [7:0] CODE_50 = 8'h50, CODE_51 = 8'h51, CODE_52 = 8'h52, CODE_53 = 8'h53;
    localparam logic [7:0] CODE_54 = 8'h54, CODE_55 = 8'h55, CODE_56 = 8'h56, CODE_57 = 8'h57;
    localparam logic [7:0] CODE_58 = 8'h58, CODE_59 = 8'h59, CODE_5A = 8'h5A, CODE_5B = 8'h5B;
    localparam logic [7:0] CODE_5C = 8'h5C, CODE_5D = 8'h5D, CODE_5E = 8'h5E, CODE_5F = 8'h5F;
    localparam logic [7:0] CODE_60 = 8'h60, CODE_61 = 8'h61, CODE_62 = 8'h62, CODE_63 = 8'h63;
    localparam logic [7:0] CODE_65 = 8'h65, CODE_66 = 8'h66, CODE_67 = 8'h67, CODE_68 = 8'h68;
    localparam logic [7:0] CODE_69 = 8'h69, CODE_6A = 8'h6A, CODE_6B = 8'h6B, CODE_6F = 8'h6F;
    localparam logic [7:0] CODE_70 = 8'h70, CODE_71 = 8'h71, CODE_72 = 8'h72, CODE_73 = 8'h73;
    localparam logic [7:0] CODE_74 = 8'h74, CODE_75 = 8'h75, CODE_76 = 8'h76, CODE_77 = 8'h77;
    localparam logic [7:0] CODE_78 = 8'h78, CODE_7A = 8'h7A, CODE_7B = 8'h7B, CODE_7C = 8'h7C;
    localparam logic [7:0] CODE_7D = 8'h7D, CODE_7E = 8'h7E, CODE_7F = 8'h7F, CODE_80 = 8'h80;
    localparam logic [7:0] CODE_81 = 8'h81, CODE_82 = 8'h82, CODE_83 = 8'h83;

    typedef struct packed {
        logic [7:0] param;
        logic [7:0] code;
    } msg_s;

    function automatic logic [3:0] msg_class(input logic [7:0] code);
        unique case (code)
            CODE_55, CODE_57: msg_class = 4'h0;
            CODE_72: msg_class = 4'h1;
            CODE_6F: msg_class = 4'h2;
            CODE_70: msg_class = 4'h3;
            CODE_5B, CODE_5C, CODE_5D, CODE_5E, CODE_5F, CODE_65, CODE_68: msg_class = 4'h4;
            CODE_50, CODE_51, CODE_59, CODE_69, CODE_6B, CODE_77, CODE_78: msg_class = 4'h5;
            CODE_52, CODE_53, CODE_60, CODE_61, CODE_62, CODE_63, CODE_66, CODE_67, CODE_6A,
            CODE_71, CODE_73, CODE_74, CODE_7C, CODE_7D: msg_class = CLS_ERROR;
            CODE_75, CODE_76, CODE_7E, CODE_7F, CODE_81: msg_class = CLS_NETMAP;
            CODE_80, CODE_82, CODE_83: msg_class = CLS_ALWAYS;
            default: msg_class = CLS_INFO;
        endcase
    endfunction : msg_class

endpackage : event_message_pkg

//--- design/event_message_fifo.sv
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
// Function
// RULE_01 - Event messages from all internal functions go into a 2048-entry FIFO.
// RULE_02 - Reading the message register pops the oldest message.
// RULE_03 - Empty buffer reads as code zero; host treats zero as no message.
// RULE_04 - When full, new messages are dropped, stored ones kept.
// RULE_05 - Debug mask selects stored classes; debug bits 0-5, info, error, netmap.
// RULE_06 - Each message has code and parameter; codes share command code space.
// RULE_07 - Command responses carry status 02 success, 04 refused, 09 invalid.
// RULE_08 - Host tolerates several cycles between command and its response.
// RULE_09 - Post 50 burst sent, 51 new successor, 7A burst detected with originator.
// RULE_10 - Receive faults post error codes 52, 53, 60, 61, 62, 74.
// RULE_11 - Per-packet 5B to 5F reports are gated by debug bit 4.
// RULE_12 - Transmit events 68, 65, 66, 67, 63, 73, 80 are posted.
// RULE_13 - Handshake events 54, 55, 57, 56, 58, 72 are posted.
// RULE_14 - Token events 6F, 70, 71, 82, 59 are posted.
// RULE_15 - Node status 75 encodes presence bits; absent nodes produce no entry.
// RULE_16 - Node list emits 7F, 75, 76 per node, max 8, then 7E.
// RULE_17 - Codes 77 and 78 posted only with node-list option built in.
// RULE_18 - Overflows post 6A command queue, 7C internal queue, 7D host buffer.
// RULE_19 - Unclassifiable line element posts 69 with frame id, debug bit 5.
// RULE_20 - Diagnostic burst posts 7B with the minor version byte.
// RULE_21 - Post 5A on response timeout, 6B on activity timer expiry.
// RULE_22 - Post 81 when network map complete, 83 with reconfiguration starter.
// RULE_23 - Half-occupancy flag raised when buffer reaches half.
// RULE_24 - Error flag pulses when an error message enters the buffer.
// RULE_25 - Each entry stores 8-bit code with its 8-bit parameter.
// RULE_26 - Registered full, empty and half flags follow each push or pop.
module event_message_fifo
    import event_message_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic evt_valid,
    input wire msg_s evt,
    input wire logic netmap_option_en,
    output logic [7:0] nl_node_id,
    input wire logic [7:0] nl_status,
    output logic buffer_half_flag,
    output logic error_logged_flag
);

    typedef enum logic [2:0] {W_IDLE, W_READ, W_ID, W_STS, W_NXT, W_DONE} walk_e;

    msg_s mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic full_q;
    logic empty_q;
    logic [MASK_W-1:0] debug_level_mask_q;
    logic [31:0] hrdata_q;
    logic wr_pend_q;
    logic [3:0] wr_ofs_q;
    logic rd_req;
    logic wr_req;
    logic pop;
    logic push;
    logic cmd_wr;
    logic [7:0] cmd_code;
    logic [7:0] cmd_param;
    msg_s resp_q;
    logic resp_valid_q;
    logic ovf_host_q;
    logic ovf_int_q;
    logic ovf_cmd_q;
    walk_e walk_q;
    logic [7:0] walk_id_q;
    logic [7:0] walk_sts_q;
    logic [3:0] walk_cnt_q;
    logic [7:0] walk_resume_q;
    logic walk_start;
    logic walk_emit;
    msg_s walk_msg;
    msg_s sel_msg;
    logic sel_valid;
    logic g_host;
    logic g_int;
    logic g_cmd;
    logic g_resp;
    logic g_walk;
    logic g_evt;
    logic [3:0] sel_class;
    logic [MASK_W:0] class_en;
    logic sel_keep;
    logic drop_full;
    logic half_q;
    logic err_q;

    // AHB-Lite slave: zero wait states, always OKAY
    assign rd_req = hsel && hready && htrans[1] && !hwrite;
    assign wr_req = hsel && hready && htrans[1] && hwrite;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    // Unmapped aliases of the message word must not pop
    assign pop = rd_req && (haddr[31:4] == 28'h0000000) && (haddr[3:0] == OFS_MESSAGE)
                 && !empty_q;  // [RULE_02]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_ofs_q <= 4'h0;
        end else begin
            wr_pend_q <= wr_req && (haddr[31:4] == 28'h0000000);
            wr_ofs_q <= haddr[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_req) begin
            hrdata_q <= 32'h00000000;
            if (haddr[31:4] == 28'h0000000) begin
                unique case (haddr[3:0])
                    // Code and parameter leave together from one entry
                    OFS_MESSAGE: hrdata_q <= empty_q ? 32'h00000000
                                           : {16'h0000, mem[rd_ptr_q]};  // [RULE_03] [RULE_25]
                    OFS_DEBUG: hrdata_q <= {23'h000000, debug_level_mask_q};
                    OFS_STATUS: hrdata_q <= {16'h0000, count_q, half_q, full_q, empty_q,
                                             resp_valid_q};
                    default: hrdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    assign cmd_wr = wr_pend_q && (wr_ofs_q == OFS_COMMAND);
    assign cmd_code = hwdata[7:0];
    assign cmd_param = hwdata[15:8];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            debug_level_mask_q <= MASK_RESET;
        end else if (wr_pend_q && wr_ofs_q == OFS_DEBUG) begin
            debug_level_mask_q <= hwdata[MASK_W-1:0];  // [RULE_05]
        end else if (cmd_wr && !resp_valid_q && cmd_code == SET_DEBUG_FILTER_COMMAND) begin
            debug_level_mask_q <= {debug_level_mask_q[MASK_W-1:8], cmd_param};  // [RULE_05]
        end
    end

    // One response slot; a command arriving while it is taken is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resp_valid_q <= 1'b0;
            resp_q <= '0;
        end else if (cmd_wr && !resp_valid_q) begin
            resp_valid_q <= 1'b1;
            resp_q.code <= cmd_code;  // [RULE_06]
            if (cmd_code == SET_DEBUG_FILTER_COMMAND) begin
                resp_q.param <= STS_SUCCESS;  // [RULE_07]
            end else if (cmd_code == NODE_LIST_REQUEST_COMMAND) begin
                resp_q.param <= (netmap_option_en && walk_q == W_IDLE)
                                ? STS_SUCCESS : STS_REFUSED;  // [RULE_07]
            end else begin
                resp_q.param <= STS_INVALID;  // [RULE_07]
            end
        end else if (g_resp) begin
            resp_valid_q <= 1'b0;
        end
    end

    assign walk_start = cmd_wr && !resp_valid_q && cmd_code == NODE_LIST_REQUEST_COMMAND
                        && netmap_option_en && walk_q == W_IDLE;

    // Node list scan; table answers in the cycle the id is shown
    assign nl_node_id = walk_id_q;
    assign walk_emit = (walk_q == W_ID) || (walk_q == W_STS) || (walk_q == W_NXT)
                       || (walk_q == W_DONE);

    always_comb begin
        walk_msg = '0;
        unique case (walk_q)
            W_ID: walk_msg = '{param: walk_id_q, code: CODE_7F};  // [RULE_16]
            W_STS: walk_msg = '{param: walk_sts_q, code: CODE_75};  // [RULE_15]
            W_NXT: walk_msg = '{param: walk_resume_q, code: CODE_76};  // [RULE_16]
            W_DONE: walk_msg = '{param: walk_resume_q, code: CODE_7E};  // [RULE_16]
            default: walk_msg = '0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            walk_q <= W_IDLE;
            walk_id_q <= 8'h00;
            walk_sts_q <= 8'h00;
            walk_cnt_q <= 4'h0;
            walk_resume_q <= 8'h00;
        end else begin
            unique case (walk_q)
                W_IDLE: if (walk_start) begin
                    walk_id_q <= cmd_param;
                    walk_cnt_q <= 4'h0;
                    walk_q <= W_READ;
                end
                W_READ: begin
                    walk_sts_q <= nl_status;
                    walk_resume_q <= (walk_id_q == LAST_NODE_ID) ? 8'h00 : walk_id_q + 8'h01;
                    if (|{nl_status[4:3], nl_status[1:0]}) begin
                        walk_q <= W_ID;  // [RULE_15]
                    end else if (walk_id_q == LAST_NODE_ID) begin
                        walk_q <= W_DONE;
                    end else begin
                        walk_id_q <= walk_id_q + 8'h01;
                    end
                end
                W_ID: if (g_walk) walk_q <= W_STS;
                W_STS: if (g_walk) walk_q <= W_NXT;
                W_NXT: if (g_walk) begin
                    walk_cnt_q <= walk_cnt_q + 4'h1;
                    if (walk_cnt_q + 4'h1 == NODE_LIST_MAX || walk_id_q == LAST_NODE_ID) begin
                        walk_q <= W_DONE;  // [RULE_16]
                    end else begin
                        walk_id_q <= walk_id_q + 8'h01;
                        walk_q <= W_READ;
                    end
                end
                W_DONE: if (g_walk) walk_q <= W_IDLE;
            endcase
        end
    end

    // One push per cycle; overflow reports first, event port last
    always_comb begin
        g_host = 1'b0;
        g_int = 1'b0;
        g_cmd = 1'b0;
        g_resp = 1'b0;
        g_walk = 1'b0;
        g_evt = 1'b0;
        sel_valid = 1'b1;
        sel_msg = '0;
        if (ovf_host_q && !full_q) begin
            g_host = 1'b1;
            sel_msg = '{param: 8'h00, code: CODE_7D};  // [RULE_18]
        end else if (ovf_int_q) begin
            g_int = 1'b1;
            sel_msg = '{param: 8'h00, code: CODE_7C};  // [RULE_18]
        end else if (ovf_cmd_q) begin
            g_cmd = 1'b1;
            sel_msg = '{param: 8'h00, code: CODE_6A};  // [RULE_18]
        end else if (resp_valid_q) begin
            g_resp = 1'b1;
            sel_msg = resp_q;  // [RULE_08]
        end else if (walk_emit) begin
            g_walk = 1'b1;
            sel_msg = walk_msg;
        end else if (evt_valid) begin
            g_evt = 1'b1;
            sel_msg = evt;  // [RULE_01] [RULE_09] [RULE_10] [RULE_12] [RULE_13] [RULE_14]
        end else begin
            sel_valid = 1'b0;
        end
    end

    // Class filter; node options and presence gate some codes
    assign sel_class = msg_class(sel_msg.code);
    assign class_en = {1'b1, debug_level_mask_q};
    always_comb begin
        sel_keep = sel_valid && class_en[sel_class];  // [RULE_05] [RULE_11] [RULE_19] [RULE_21]
        if ((sel_msg.code == CODE_77 || sel_msg.code == CODE_78) && !netmap_option_en) begin
            sel_keep = 1'b0;  // [RULE_17]
        end
        if (sel_msg.code == CODE_75 && !(|{sel_msg.param[4:3], sel_msg.param[1:0]})) begin
            sel_keep = 1'b0;  // [RULE_15]
        end
        if (sel_msg.code == NULL_CODE) begin
            sel_keep = 1'b0;  // [RULE_03]
        end
    end
    // 7A, 7B pass as info class, 81 as netmap class, 83 as always-stored class [RULE_20] [RULE_22]

    assign push = sel_keep && !full_q;  // [RULE_04]
    assign drop_full = sel_keep && full_q;

    // Set beats clear on every overflow flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_host_q <= 1'b0;
            ovf_int_q <= 1'b0;
            ovf_cmd_q <= 1'b0;
        end else begin
            ovf_host_q <= drop_full || (ovf_host_q && !g_host);  // [RULE_18]
            ovf_int_q <= (evt_valid && !g_evt) || (ovf_int_q && !g_int);  // [RULE_18]
            ovf_cmd_q <= (cmd_wr && resp_valid_q) || (ovf_cmd_q && !g_cmd);  // [RULE_18]
        end
    end

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr_q] <= sel_msg;  // [RULE_01] [RULE_25]
        end
    end

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 12'h001;
        end else if (pop && !push) begin
            count_d = count_q - 12'h001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= CNT_RESET;
            full_q <= 1'b0;
            empty_q <= 1'b1;
            half_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 11'h001;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 11'h001;  // [RULE_02]
            end
            count_q <= count_d;
            full_q <= (count_d == CNT_FULL);  // [RULE_26]
            empty_q <= (count_d == CNT_RESET);  // [RULE_26]
            half_q <= (count_d >= CNT_HALF);  // [RULE_26] [RULE_23]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_q <= 1'b0;
        end else begin
            err_q <= push && (sel_class == CLS_ERROR);  // [RULE_24]
        end
    end

    assign buffer_half_flag = half_q;
    assign error_logged_flag = err_q;

endmodule : event_message_fifo

//--- tb/event_message_fifo_asserts.sv
`timescale 1ns/100ps
module event_message_fifo_asserts
    import event_message_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic buffer_half_flag
);
    logic rd_any;
    logic rd_msg;
    logic rd_sts;
    assign rd_any = hsel && hready && htrans[1] && !hwrite;
    assign rd_msg = rd_any && haddr == 32'h0;
    assign rd_sts = rd_any && haddr == {28'h0, OFS_STATUS};
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    no_wait_a: assert property (hreadyout)
        else $error("slave inserted a wait state");
    okay_resp_a: assert property (!hresp)
        else $error("slave answered with an error");
    word_pairing_a: assert property (rd_msg |=> hrdata[31:16] == 16'h0000)
        else $error("message word has bits above the parameter");
    null_param_a: assert property (rd_msg |=> hrdata[7:0] != 8'h00 || hrdata[15:8] == 8'h00)
        else $error("null code came with a parameter");
    half_status_a: assert property (rd_sts |=> hrdata[3] == (hrdata[15:4] >= CNT_HALF))
        else $error("half bit disagrees with fill count");
    full_status_a: assert property (rd_sts |=> hrdata[2] == (hrdata[15:4] == CNT_FULL))
        else $error("full bit disagrees with fill count");
    empty_status_a: assert property (rd_sts |=> hrdata[1] == (hrdata[15:4] == CNT_RESET))
        else $error("empty bit disagrees with fill count");
    depth_bound_a: assert property (rd_sts |=> hrdata[15:4] <= CNT_FULL)
        else $error("fill count beyond buffer depth");
    half_flag_a: assert property (rd_sts |=> hrdata[3] == $past(buffer_half_flag))
        else $error("half flag disagrees with status");
    half_fall_a: assert property ($fell(buffer_half_flag) |-> $past(rd_msg))
        else $error("half flag fell without a pop");
    rdata_hold_a: assert property (!rd_any |=> $stable(hrdata))
        else $error("read data changed without a read");
endmodule : event_message_fifo_asserts

//--- tb/node_table_model.sv
`timescale 1ns/100ps
module node_table_model (
    input wire logic [7:0] nl_node_id,
    output logic [7:0] nl_status
);
    // Every fourth id absent so the scan must skip
    always_comb begin
        case (nl_node_id[1:0])
            2'h0: nl_status = 8'h00;
            2'h1: nl_status = 8'h05;
            2'h2: nl_status = 8'h02;
            default: nl_status = 8'h18;
        endcase
    end
endmodule : node_table_model

//--- tb/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("Error t=%0t got %h expected %h", $time, (g), (e)); \
    end \
end
module tb;
    import event_message_pkg::*;
    logic hclk, hresetn, hsel, hwrite, evt_valid, netmap_option_en;
    logic hreadyout, hresp, buffer_half_flag, error_logged_flag;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] nl_node_id, nl_status;
    logic [8:0] m;
    logic [15:0] lf;
    logic [15:0] expq [$];
    logic [23:0] cmds [3] = '{24'h02C520, 24'h040121, 24'h095A33};
    logic [15:0] nl_end [9] = '{16'h0221, 16'hFE7F, 16'h0421, 16'h0275, 16'hFF76, 16'hFF7F,
        16'h1875, 16'h0076, 16'h007E};
    msg_s evt;
    int mismatches, check_count, cycles, err_pulses, exp_err;

    event_message_fifo u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .evt_valid(evt_valid), .evt(evt), .netmap_option_en(netmap_option_en),
        .nl_node_id(nl_node_id), .nl_status(nl_status),
        .buffer_half_flag(buffer_half_flag), .error_logged_flag(error_logged_flag));
    node_table_model u_nodes (.nl_node_id(nl_node_id), .nl_status(nl_status));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic int cls(input logic [7:0] c);
        case (c)
            8'h55, 8'h57: return 0;
            8'h72: return 1;
            8'h6F: return 2;
            8'h70: return 3;
            8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'h65, 8'h68: return 4;
            8'h50, 8'h51, 8'h59, 8'h69, 8'h6B, 8'h77, 8'h78: return 5;
            8'h52, 8'h53, 8'h60, 8'h61, 8'h62, 8'h63, 8'h66, 8'h67, 8'h6A, 8'h71, 8'h73,
            8'h74, 8'h7C, 8'h7D: return 7;
            8'h75, 8'h76, 8'h7E, 8'h7F, 8'h81: return 8;
            8'h80, 8'h82, 8'h83: return 9;
            default: return 6;
        endcase
    endfunction : cls

    function automatic bit keep(input logic [7:0] c, input logic [7:0] p, input logic [8:0] k);
        if (c == 8'h00 || (cls(c) < 9 && !k[cls(c)])) return 0;
        if (c == 8'h75 && (p & 8'h1B) == 8'h00) return 0;
        return !((c == 8'h77 || c == 8'h78) && !netmap_option_en);
    endfunction : keep

    function automatic logic [7:0] node_st(input int id);
        return (id % 4 == 1) ? 8'h05 : (id % 4 == 2) ? 8'h02 : 8'h18;
    endfunction : node_st

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    // Holds each phase until hready is sampled high
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
        rdat = hrdata;
        if (n >= 100) mismatches++;
    endtask : bus

    task automatic post(input logic [7:0] c, input logic [7:0] p, input logic [8:0] k);
        evt_valid <= 1'b1;
        evt <= {p, c};
        if (keep(c, p, k)) begin
            expq.push_back({p, c});
            exp_err += (cls(c) == 7);
        end
        @(posedge hclk);
    endtask : post

    // Zero means nothing yet; responses arrive some cycles late
    task automatic drain();
        int n;
        while (expq.size() > 0) begin
            n = 0;
            bus(32'h0, 1'b0, 32'h0);
            while (rdat === 32'h0 && n < 100) begin
                n++;
                bus(32'h0, 1'b0, 32'h0);
            end
            `CHK(rdat, {16'h0, expq.pop_front()})
        end
        bus(32'h0, 1'b0, 32'h0);
        `CHK(rdat, 32'h0)
    endtask : drain

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cycles++;
        if (error_logged_flag === 1'b1) err_pulses++;
        if (cycles == 60000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        {hresetn, hsel, hwrite, evt_valid, netmap_option_en} = 5'h00;
        {haddr, hwdata, htrans, evt} = '0;
        hsize = 3'h2;
        lf = 16'h5DDE;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(32'h0, 1'b0, 32'h0);
        `CHK(rdat, 32'h0)
        bus({28'h0, OFS_STATUS}, 1'b0, 32'h0);
        `CHK(rdat, 32'h2)
        bus(32'h10, 1'b1, 32'hFFFFFFFF);
        bus(32'h10, 1'b0, 32'h0);
        `CHK(rdat, 32'h0)
        $display("test reset finished");
        for (int r = 0; r < 4; r++) begin
            lf = lfsr(lf);
            m = (r == 0) ? MASK_RESET : lf[8:0];
            netmap_option_en <= r[0];
            if (r > 0) bus({28'h0, OFS_DEBUG}, 1'b1, {23'h0, m});
            bus({28'h0, OFS_DEBUG}, 1'b0, 32'h0);
            `CHK(rdat, {23'h0, m})
            for (int c = 8'h4F; c <= 8'h84; c++) begin
                lf = lfsr(lf);
                post(c[7:0], lf[7:0], m);
            end
            post(8'h00, lf[15:8], m);
            evt_valid <= 1'b0;
            drain();
        end
        $display("test filter finished");
        bus({28'h0, OFS_DEBUG}, 1'b1, {23'h0, MASK_RESET});
        netmap_option_en <= 1'b0;
        foreach (cmds[i]) begin
            bus({28'h0, OFS_COMMAND}, 1'b1, {16'h0, cmds[i][15:0]});
            bus({28'h0, OFS_STATUS}, 1'b0, 32'h0);
            `CHK(rdat, 32'h3)
            expq.push_back({cmds[i][23:16], cmds[i][7:0]});
            drain();
        end
        bus({28'h0, OFS_DEBUG}, 1'b0, 32'h0);
        `CHK(rdat, 32'h1C5)
        netmap_option_en <= 1'b1;
        bus({28'h0, OFS_COMMAND}, 1'b1, {16'h0, 8'h01, NODE_LIST_REQUEST_COMMAND});
        expq.push_back({STS_SUCCESS, NODE_LIST_REQUEST_COMMAND});
        for (int id = 1; id <= 10; id++) begin
            if (id % 4 != 0) begin
                expq.push_back({id[7:0], 8'h7F});
                expq.push_back({node_st(id), 8'h75});
                expq.push_back({id[7:0] + 8'h01, 8'h76});
            end
        end
        expq.push_back({8'h0B, 8'h7E});
        drain();
        // Second request lands while the first list runs; list ends at the last id
        bus({28'h0, OFS_COMMAND}, 1'b1, {16'h0, 8'hFE, NODE_LIST_REQUEST_COMMAND});
        bus({28'h0, OFS_COMMAND}, 1'b1, {16'h0, 8'hFE, NODE_LIST_REQUEST_COMMAND});
        foreach (nl_end[i]) expq.push_back(nl_end[i]);
        drain();
        // Event pulse meets the response slot and is lost
        bus({28'h0, OFS_COMMAND}, 1'b1, {16'h0, 8'h11, 8'h44});
        evt_valid <= 1'b1;
        evt <= {8'h11, 8'h7A};
        @(posedge hclk);
        evt_valid <= 1'b0;
        bus(32'h10, 1'b0, 32'h0);
        `CHK(rdat, 32'h0)
        expq.push_back({STS_INVALID, 8'h44});
        expq.push_back({8'h00, 8'h7C});
        exp_err++;
        drain();
        $display("test commands finished");
        for (int i = 0; i < FIFO_DEPTH + 3; i++) post(8'h7A, i[7:0], 9'h1C5);
        repeat (3) void'(expq.pop_back());
        evt_valid <= 1'b0;
        bus({28'h0, OFS_STATUS}, 1'b0, 32'h0);
        `CHK(rdat, 32'h800C)
        `CHK(buffer_half_flag, 1'b1)
        expq.push_back({8'h00, 8'h7D});
        exp_err++;
        drain();
        `CHK(buffer_half_flag, 1'b0)
        `CHK(err_pulses, exp_err)
        $display("test full finished");
        give_verdict();
    end
endmodule : tb

bind event_message_fifo event_message_fifo_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .buffer_half_flag(buffer_half_flag));
